// [cac_capture.sv]
// Five-module counter array capture block with APB register access
`timescale 1ns/1ps
`include "cac_regs.svh"

module cac_capture
  import cac_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // Capture pins
  input  wire logic [4:0]  module_io_pin,
  // Interrupt and decoded functions
  output logic             irq,
  output logic      [14:0] module_func
);

  // Mode decode shared by capture qualification and function report
  function automatic cac_func_type decode_mode(input logic [7:0] m,
                                               input logic       wdog);
    logic cmp;
    logic edg;
    logic oth;
    cmp = m[`CAC_BIT_COMP];
    edg = m[`CAC_BIT_RISE] | m[`CAC_BIT_FALL];
    oth = m[`CAC_BIT_MATCH] | m[`CAC_BIT_TOGGLE] | m[`CAC_BIT_PWM];
    if ((m & `CAC_MODE_MASK) == 8'h00) begin
      decode_mode = CAC_FN_NONE;
    end else if (edg && !oth) begin
      decode_mode = CAC_FN_CAP;
    end else if (cmp && !edg && m[`CAC_BIT_MATCH] && !m[`CAC_BIT_PWM]) begin
      if (wdog) begin
        decode_mode = CAC_FN_WDOG;
      end else if (m[`CAC_BIT_TOGGLE]) begin
        decode_mode = CAC_FN_HSO;
      end else begin
        decode_mode = CAC_FN_TIMER;
      end
    end else if (cmp && !edg && !m[`CAC_BIT_MATCH] && !m[`CAC_BIT_TOGGLE]
                 && m[`CAC_BIT_PWM] && !m[`CAC_BIT_IRQ_EN]) begin
      decode_mode = CAC_FN_PWM;
    end else begin
      decode_mode = CAC_FN_UNDEF;
    end
  endfunction

  logic [7:0]  mode_r [0:4];
  logic [4:0]  pin_meta_r;
  logic [4:0]  pin_sync_r;
  logic [4:0]  pin_prev_r;
  logic [4:0]  rise_stb;
  logic [4:0]  fall_stb;
  logic [4:0]  cap_stb;
  logic [15:0] count_r;
  logic        run_r;
  logic [4:0]  evt_flag_r;
  logic [4:0]  evt_en_r;
  logic [4:0]  evt_clr;
  logic [4:0]  irq_src;
  logic [15:0] cap_rd;
  logic [2:0]  cap_idx;
  logic        cap_hi_r;
  logic        cap_sel_r;
  logic [31:0] rd_nxt;
  logic [31:0] rd_r;
  logic        err_nxt;
  logic        err_r;
  logic        setup;
  logic        wr_acc;
  logic        rd_pend_r;
  logic [3:0]  mode_wr_idx;
  logic        mode_wr;
  cac_func_type fn [0:4];

  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pready;

  // Reads take two access cycles: setup loads the capture store, the second access cycle returns data
  assign pready  = !setup && (pwrite || rd_pend_r);
  assign prdata  = rd_r;
  assign pslverr = err_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_r <= 1'b0;
    end else begin
      // Set in the first access cycle so a read answers in the second
      rd_pend_r <= psel && penable && !pwrite && !rd_pend_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= 5'h00;
      pin_sync_r <= 5'h00;
      pin_prev_r <= 5'h00;
    end else begin
      pin_meta_r <= module_io_pin;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  assign rise_stb = pin_sync_r & ~pin_prev_r;
  assign fall_stb = ~pin_sync_r & pin_prev_r;

  genvar g;
  generate
    for (g = 0; g < `CAC_NUM_MOD; g++) begin : g_mod
      assign fn[g] = decode_mode(mode_r[g], g == `CAC_WDOG_MOD);
      assign module_func[3*g +: 3] = fn[g];
      assign cap_stb[g] = (fn[g] == CAC_FN_CAP) &&
        ((rise_stb[g] && mode_r[g][`CAC_BIT_RISE]) ||
         (fall_stb[g] && mode_r[g][`CAC_BIT_FALL]));
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 16'h0000;
    end else if (wr_acc && paddr == `CAC_CNTLO_ADDR) begin
      count_r <= {count_r[15:8], pwdata[7:0]};
    end else if (wr_acc && paddr == `CAC_CNTHI_ADDR) begin
      count_r <= {pwdata[7:0], count_r[7:0]};
    end else if (run_r) begin
      count_r <= count_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
    end else if (wr_acc && paddr == `CAC_CTRL_ADDR) begin
      run_r <= pwdata[`CAC_BIT_RUN];
    end
  end

  assign mode_wr_idx = 4'(paddr[11:2] - `CAC_MODE_BASE / 4);
  assign mode_wr = wr_acc && paddr >= `CAC_MODE_BASE &&
                   paddr < `CAC_MODE_BASE + 12'h014;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 5; i++) begin
        mode_r[i] <= `CAC_MODE_RST;
      end
    end else if (mode_wr) begin
      mode_r[3'(mode_wr_idx)] <= pwdata[7:0] & `CAC_MODE_MASK;
    end
  end

  // copy full counter on qualified edge
  cac_cap_mem u_mem (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .wr_en     (cap_stb),
    .wr_data   (count_r),
    .rd_idx    (cap_idx),
    .rd_data_r (cap_rd)
  );

  assign cap_idx = paddr >= `CAC_CAPHI_BASE ?
                   3'(paddr[11:2] - `CAC_CAPHI_BASE / 4) :
                   3'(paddr[11:2] - `CAC_CAPLO_BASE / 4);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap_hi_r  <= 1'b0;
      cap_sel_r <= 1'b0;
    end else if (setup) begin
      cap_hi_r  <= paddr >= `CAC_CAPHI_BASE;
      cap_sel_r <= paddr >= `CAC_CAPLO_BASE &&
                   paddr < `CAC_CAPHI_BASE + 12'h014 &&
                   (paddr < `CAC_CAPLO_BASE + 12'h014 ||
                    paddr >= `CAC_CAPHI_BASE);
    end
  end

  // capture sets event flag, set wins over clear
  assign evt_clr = (wr_acc && paddr == `CAC_EVT_CLR_ADDR) ?
                   pwdata[4:0] : 5'h00;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_flag_r <= 5'h00;
    end else begin
      evt_flag_r <= (evt_flag_r & ~evt_clr) | cap_stb;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_en_r <= 5'h1F;
    end else if (wr_acc && paddr == `CAC_EVT_EN_ADDR) begin
      evt_en_r <= pwdata[4:0];
    end
  end

  // flag, enable bit and mode bit 0 raise interrupt
  generate
    for (g = 0; g < `CAC_NUM_MOD; g++) begin : g_irq
      assign irq_src[g] = evt_flag_r[g] && evt_en_r[g] &&
                          mode_r[g][`CAC_BIT_IRQ_EN];
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |irq_src;
    end
  end

  // Read mux; registered in the cycle before the slave answers
  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr >= `CAC_MODE_BASE && paddr < `CAC_MODE_BASE + 12'h014) begin
      rd_nxt = {24'h000000, mode_r[3'(mode_wr_idx)]};
    end else if (cap_sel_r) begin
      rd_nxt = {24'h000000, cap_hi_r ? cap_rd[15:8] : cap_rd[7:0]};
    end else if (paddr == `CAC_CNTLO_ADDR) begin
      rd_nxt = {24'h000000, count_r[7:0]};
    end else if (paddr == `CAC_CNTHI_ADDR) begin
      rd_nxt = {24'h000000, count_r[15:8]};
    end else if (paddr == `CAC_CTRL_ADDR) begin
      rd_nxt = {31'h0000_0000, run_r};
    end else if (paddr == `CAC_EVT_STAT_ADDR) begin
      rd_nxt = {27'h0000000, evt_flag_r};
    end else if (paddr == `CAC_EVT_EN_ADDR) begin
      rd_nxt = {27'h0000000, evt_en_r};
    end else if (paddr != `CAC_EVT_CLR_ADDR) begin
      err_nxt = `CAC_ERR_RESP;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r  <= 32'h0000_0000;
      err_r <= 1'b0;
    end else begin
      rd_r  <= (psel && !pwrite) ? rd_nxt : 32'h0000_0000;
      // Unmapped writes are dropped silently, only reads report
      err_r <= psel && !pwrite && err_nxt && !pready;
    end
  end

  // Assertions
  AST_CAP_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
    cap_stb[0] |=> evt_flag_r[0])
    else $error("capture did not set flag");
  AST_FLAG_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    evt_flag_r[1] && evt_clr[1] == 1'b0 |=> evt_flag_r[1])
    else $error("flag dropped without clear");
  AST_IRQ: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_src[2] |=> irq)
    else $error("irq missing");
  AST_RISE_ONLY: assert property (@(posedge mclk) disable iff (!rst_n)
    fall_stb[0] && !mode_r[0][`CAC_BIT_FALL] |-> !cap_stb[0])
    else $error("falling edge captured without enable");
  AST_MODE_CAP: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_r[3][`CAC_BIT_MATCH] |-> !cap_stb[3])
    else $error("capture in compare mode");
  AST_EDGE: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(pin_sync_r[4]) |-> rise_stb[4] ##1 !rise_stb[4])
    else $error("edge strobe wrong");
  AST_SYNC: assert property (@(posedge mclk) disable iff (!rst_n)
    cap_stb[1] |-> pin_sync_r[1] != pin_prev_r[1])
    else $error("capture without pin change");
  AST_RSVD: assert property (@(posedge mclk) disable iff (!rst_n)
    !mode_r[0][`CAC_BIT_RSVD])
    else $error("reserved bit stored");
  AST_WDOG: assert property (@(posedge mclk) disable iff (!rst_n)
    fn[0] != CAC_FN_WDOG)
    else $error("watchdog on wrong module");
  COV_CAP: cover property (@(posedge mclk) cap_stb[0]);
  COV_BOTH: cover property (@(posedge mclk) cap_stb[2] ##[1:50] cap_stb[2]);
  COV_IRQ: cover property (@(posedge mclk) $rose(irq));
endmodule

// [cac_regs.svh]
// Register offsets, field positions and reset values of the capture array
`ifndef CAC_REGS_SVH
`define CAC_REGS_SVH

`define CAC_NUM_MOD        5
`define CAC_MODE_BASE      12'h000
`define CAC_CAPLO_BASE     12'h020
`define CAC_CAPHI_BASE     12'h040
`define CAC_CNTLO_ADDR     12'h060
`define CAC_CNTHI_ADDR     12'h064
`define CAC_CTRL_ADDR      12'h068
`define CAC_EVT_STAT_ADDR  12'h070
`define CAC_EVT_CLR_ADDR   12'h074
`define CAC_EVT_EN_ADDR    12'h078

`define CAC_BIT_RSVD       7
`define CAC_BIT_COMP       6
`define CAC_BIT_RISE       5
`define CAC_BIT_FALL       4
`define CAC_BIT_MATCH      3
`define CAC_BIT_TOGGLE     2
`define CAC_BIT_PWM        1
`define CAC_BIT_IRQ_EN     0
`define CAC_BIT_RUN        0

`define CAC_MODE_RST       8'h00
`define CAC_MODE_MASK      8'h7F
`define CAC_WDOG_MOD       4
`define CAC_ERR_RESP       1'b1

`endif

// [cac_pkg.sv]
// Types shared by the capture array
package cac_pkg;
  typedef enum logic [2:0] {
    CAC_FN_NONE   = 3'b000,
    CAC_FN_CAP    = 3'b001,
    CAC_FN_TIMER  = 3'b010,
    CAC_FN_HSO    = 3'b011,
    CAC_FN_PWM    = 3'b100,
    CAC_FN_WDOG   = 3'b101,
    CAC_FN_UNDEF  = 3'b110
  } cac_func_type;
endpackage

// [cac_cap_mem.sv]
// Capture value store: one 16-bit word per module, registered read port
`timescale 1ns/1ps
module cac_cap_mem (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Write port, one enable per module
  input  wire logic [4:0]  wr_en,
  input  wire logic [15:0] wr_data,
  // Registered read port
  input  wire logic [2:0]  rd_idx,
  output logic      [15:0] rd_data_r
);
  logic [15:0] word_r [0:4];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 5; i++) begin
        word_r[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (wr_en[i]) begin
          word_r[i] <= wr_data;
        end
      end
    end
  end

  // Write-through so a capture in the read cycle shows at once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= 16'h0000;
    end else if (rd_idx < 3'h5) begin
      rd_data_r <= wr_en[rd_idx] ? wr_data : word_r[rd_idx];
    end else begin
      rd_data_r <= 16'h0000;
    end
  end
endmodule

// [cac_pin_src.sv]
// Behavioural source for the five capture pins
`timescale 1ns/1ps
module cac_pin_src (
  // Clock
  input  wire logic       mclk,
  // Capture pins
  output logic      [4:0] pins
);
  initial begin
    pins = 5'h00;
  end
  // Change one pin after a lag, prompt when lag is zero
  task automatic drive(input int idx, input logic val, input int lag);
    repeat (lag) @(posedge mclk);
    pins[idx] <= val;
  endtask
endmodule

// [testbench.sv]
// Self-checking bench for the capture array
`timescale 1ns/1ps
`include "cac_regs.svh"
module testbench
  import cac_pkg::*;
;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  pins;
  logic [14:0] module_func;
  logic [7:0]  modes [9];
  int          fexp [9];
  int          mdl_cap [5];
  int          fails, checks, flags, en, e, n, cnt, msk;
  logic [7:0]  cmode [5];
  logic        nv;

  cac_capture u_cac_capture (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .module_io_pin(pins), .irq(irq), .module_func(module_func));
  cac_pin_src u_cac_pin_src (.mclk(mclk), .pins(pins));

  always #12.5 mclk = ~mclk;

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // Pre-edge values: design registers settle only in the NBA region
    while (pready !== 1'b1) begin
      k++;
      if (k > 20) begin
        fails++;
        give_verdict();
      end
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; fails = 0; checks = 0; flags = 0;
    modes = '{8'h60, 8'h10, 8'h30, 8'h71, 8'h48, 8'h4C, 8'h42, 8'h00, 8'h49};
    fexp = '{1, 1, 1, 1, 2, 3, 4, 0, 2};
    cmode = '{8'h20, 8'h10, 8'h30, 8'h71, 8'h11};
    void'($urandom(32'h8DADB883));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int m = 0; m < 5; m++) begin
      apb(1'b0, `CAC_MODE_BASE + 12'(4 * m), 32'h0);
      chk("mode reset", rd, 32'h0);
    end
    chk("func reset", {17'h0, module_func}, 32'h0);
    apb(1'b0, `CAC_EVT_EN_ADDR, 32'h0);
    chk("enable reset", rd, 32'h1F);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 9; k++) begin
      for (int m = 0; m < 5; m++)
        apb(1'b1, `CAC_MODE_BASE + 12'(4 * m), {24'h0, modes[k]});
      for (int m = 0; m < 5; m++) begin
        apb(1'b0, `CAC_MODE_BASE + 12'(4 * m), 32'h0);
        chk("mode readback", rd, {24'h0, modes[k] & 8'h7F});
        e = (m == `CAC_WDOG_MOD && (fexp[k] == 2 || fexp[k] == 3)) ?
            5 : fexp[k];
        chk("func", {29'h0, module_func[3*m +: 3]}, e);
      end
    end
    $display("test decode done");
    cnt = $urandom & 32'hFFFF;
    apb(1'b1, `CAC_CNTLO_ADDR, cnt & 32'hFF);
    apb(1'b1, `CAC_CNTHI_ADDR, cnt >> 8);
    apb(1'b1, `CAC_CTRL_ADDR, 32'h1);
    repeat (20) @(posedge mclk);
    apb(1'b1, `CAC_CTRL_ADDR, 32'h0);
    // Runs from the edge after the start write through the stop write
    cnt = (cnt + 23) & 32'hFFFF;
    apb(1'b0, `CAC_CNTLO_ADDR, 32'h0);
    chk("count low", rd, cnt & 32'hFF);
    apb(1'b0, `CAC_CNTHI_ADDR, 32'h0);
    chk("count high", rd, cnt >> 8);
    $display("test counter done");
    apb(1'b1, `CAC_CTRL_ADDR, 32'h0);
    for (int m = 0; m < 5; m++)
      apb(1'b1, `CAC_MODE_BASE + 12'(4 * m), {24'h0, cmode[m]});
    for (int s = 0; s < 30; s++) begin
      n = $urandom % 5;
      cnt = $urandom & 32'hFFFF;
      en = $urandom & 32'h1F;
      apb(1'b1, `CAC_CNTLO_ADDR, cnt & 32'hFF);
      apb(1'b1, `CAC_CNTHI_ADDR, cnt >> 8);
      apb(1'b1, `CAC_EVT_EN_ADDR, en);
      nv = ~pins[n];
      u_cac_pin_src.drive(n, nv, $urandom % 3);
      repeat (8) @(posedge mclk);
      if ((nv && cmode[n][5]) || (!nv && cmode[n][4])) begin
        mdl_cap[n] = cnt;
        flags = flags | (1 << n);
      end
      apb(1'b0, `CAC_CAPLO_BASE + 12'(4 * n), 32'h0);
      chk("capture low", rd & 32'hFF, mdl_cap[n] & 32'hFF);
      apb(1'b0, `CAC_CAPHI_BASE + 12'(4 * n), 32'h0);
      chk("capture high", rd & 32'hFF, mdl_cap[n] >> 8);
      apb(1'b0, `CAC_EVT_STAT_ADDR, 32'h0);
      chk("status", rd & 32'h1F, flags);
      chk("irq", {31'h0, irq}, {31'h0, |(flags & en & 5'h18)});
      msk = $urandom & 32'h1F;
      if (s % 2 == 1) begin
        apb(1'b1, `CAC_EVT_CLR_ADDR, msk);
        flags = flags & ~msk;
        repeat (2) @(posedge mclk);
        chk("irq clear", {31'h0, irq}, {31'h0, |(flags & en & 5'h18)});
      end
    end
    $display("test capture done");
    give_verdict();
  end
endmodule
